/* dros_link_checker.sv */
// assertions on the overhead strobe link between the two ends
`timescale 1ns/1ps
`default_nettype none
module dros_link_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // link signals
  input wire logic receive_output_clock,
  input wire logic rx_overhead_serial_out,
  input wire logic overhead_sample_strobe,
  input wire logic overhead_frame_marker
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // ****************************************************************
  // helper counters
  // ****************************************************************
  logic        ck_d_r;
  logic        stb_d_r;
  logic        seen_r;
  logic [15:0] gap_r;
  logic [7:0]  mark_r;
  wire         ck_rise = receive_output_clock && !ck_d_r;
  wire         stb_fall = stb_d_r && !overhead_sample_strobe;

  // output clock rises since the last strobe, and while the marker stands
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ck_d_r <= 1'b0;
      stb_d_r <= 1'b0;
      seen_r <= 1'b0;
      gap_r <= 16'h0000;
      mark_r <= 8'h00;
    end else begin
      ck_d_r <= receive_output_clock;
      stb_d_r <= overhead_sample_strobe;
      seen_r <= seen_r || stb_fall;
      gap_r <= stb_fall ? 16'h0000 : gap_r + {15'h0000, ck_rise};
      mark_r <= overhead_frame_marker ? mark_r + {7'h00, ck_rise} : 8'h00;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_strobe_on_rise: assert property ($rose(overhead_sample_strobe) |-> $rose(receive_output_clock))
    else $error("strobe rose away from an output clock rise");
  a_strobe_one_period: assert property ($rose(receive_output_clock) && $past(overhead_sample_strobe)
    |-> !overhead_sample_strobe) else $error("strobe outlived one output clock period");
  a_strobe_mid_bit: assert property ($rose(overhead_sample_strobe) && overhead_frame_marker
    |-> mark_r == 8'h2A) else $error("strobe not at output clock 42 of the bit");
  a_marker_one_slot: assert property ($fell(overhead_frame_marker)
    |-> mark_r == 8'h55 && $rose(receive_output_clock)) else $error("marker not held 85 output clocks");
  a_marker_on_rise: assert property ($rose(overhead_frame_marker) |-> $rose(receive_output_clock))
    else $error("marker rose away from an output clock rise");
  a_data_on_rise: assert property ($changed(rx_overhead_serial_out) |-> $rose(receive_output_clock))
    else $error("overhead data changed away from an output clock rise");
  a_data_held_strobe: assert property (overhead_sample_strobe |-> $stable(rx_overhead_serial_out))
    else $error("overhead data moved under the strobe");
  a_strobe_gap: assert property ($rose(overhead_sample_strobe) && seen_r |-> gap_r >= 16'h0053)
    else $error("strobe inside payload bits");
endmodule // dros_link_checker
`default_nettype wire

/* dros_link_if.sv */
// link between the overhead output port and the terminal equipment
`timescale 1ns/1ps
`default_nettype none
interface dros_link_if;
  // all four are levels in the sys_clk domain
  logic receive_output_clock;
  logic rx_overhead_serial_out;
  logic overhead_sample_strobe;
  logic overhead_frame_marker;

  // documented device end
  modport dev (
    output receive_output_clock,
    output rx_overhead_serial_out,
    output overhead_sample_strobe,
    output overhead_frame_marker
  );

  // terminal equipment end
  modport term (
    input  receive_output_clock,
    input  rx_overhead_serial_out,
    input  overhead_sample_strobe,
    input  overhead_frame_marker
  );
endinterface // dros_link_if
`default_nettype wire

/* dros_pkg.sv */
// constants and types shared by both ends of the receive overhead strobe link
package dros_pkg;

  // ****************************************************************
  // clocking
  // ****************************************************************
  // local logic clock, in kHz
  localparam int unsigned SYS_CLK_KHZ       = 40000;
  // output clock rate in DS3 operation, in kHz
  localparam int unsigned DS3_LINE_RATE_KHZ = 44736;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  // overhead bits per frame
  localparam int unsigned    OH_PER_FRAME   = 56;
  // index of the last overhead bit of a frame
  localparam logic [5:0]     LAST_OH_IDX    = 6'h37;
  // index of the first overhead bit of a frame
  localparam logic [5:0]     FIRST_OH_IDX   = 6'h00;
  // an overhead bit is held for one block: itself plus 84 payload bits,
  // so its period is 85 output clocks, numbered 0 to 84
  localparam logic [6:0]     BIT_LAST_PHASE = 7'h54;
  // output clock within the bit period that carries the sample strobe
  localparam logic [6:0]     STROBE_PHASE   = 7'h2A;
  // first output clock of a bit period
  localparam logic [6:0]     PHASE_ZERO     = 7'h00;

  // ****************************************************************
  // buffering
  // ****************************************************************
  localparam int unsigned    OH_FIFO_DEPTH  = 8;
  // word is {first bit of frame, overhead bit}
  localparam int unsigned    OH_FIFO_WIDTH  = 2;

  // ****************************************************************
  // types
  // ****************************************************************
  // state of the device's bit slot sequencer
  typedef enum logic [0:0] {
    DROS_ST_WAIT = 1'b0,
    DROS_ST_BIT  = 1'b1
  } dros_state_t;

  // meaning of an overhead bit by its position in the frame
  typedef enum logic [3:0] {
    DROS_KIND_X    = 4'h0,
    DROS_KIND_F1   = 4'h1,
    DROS_KIND_F0   = 4'h2,
    DROS_KIND_AIC  = 4'h3,
    DROS_KIND_NA   = 4'h4,
    DROS_KIND_FEAC = 4'h5,
    DROS_KIND_UDL  = 4'h6,
    DROS_KIND_P    = 4'h7,
    DROS_KIND_CP   = 4'h8,
    DROS_KIND_FEBE = 4'h9,
    DROS_KIND_M0   = 4'hA,
    DROS_KIND_M1   = 4'hB,
    DROS_KIND_DL   = 4'hC
  } dros_kind_t;

endpackage

/* dros_rx_oh_dev.sv */
// device end: buffers overhead bits and sends them with clock, strobe and frame marker
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// synchronous fifo with registered flags
// ****************************************************************
module dros_fifo #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // filling side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // draining side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    cnt_r;
  logic [CW-1:0]    cnt_nxt;
  logic             room_r;
  logic             empty_r;
  wire              push = in_valid & room_r;
  wire              pop  = out_ready & ~empty_r;

  // flags come from registers so the ready and valid ports are glitch free
  assign in_ready  = room_r;
  assign out_valid = ~empty_r;
  assign out_data  = mem_r[rd_ptr_r];
  assign cnt_nxt   = cnt_r + CW'(push) - CW'(pop);

  // storage has no reset; only the pointers, fill level and flags need a defined start
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers, fill level and flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      room_r   <= 1'b1;
      empty_r  <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + PW'(1);
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + PW'(1);
      end
      cnt_r   <= cnt_nxt;
      room_r  <= (cnt_nxt != CNT_FULL);
      empty_r <= (cnt_nxt == '0);
    end
  end
endmodule // dros_fifo

// ****************************************************************
// overhead output port, strobe method
// ****************************************************************
module dros_rx_oh_dev (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // timing source selection
  input  wire logic loop_timing_sel,
  input  wire logic line_receive_clock,
  input  wire logic transmit_input_clock,
  // overhead bits from the receive framer, in frame order
  input  wire logic oh_valid,
  input  wire logic oh_bit,
  input  wire logic oh_first,
  output logic      oh_ready,
  // status
  output logic      underrun_pulse,
  // link to the terminal equipment
  dros_link_if.dev  link
);
  logic                 src_r;
  logic                 src_d_r;
  logic                 out_clk_r;
  dros_pkg::dros_state_t state_r;
  dros_pkg::dros_state_t state_nxt;
  logic [6:0]           phase_r;
  logic [6:0]           phase_nxt;
  logic                 data_r;
  logic                 data_nxt;
  logic                 marker_r;
  logic                 marker_nxt;
  logic                 strobe_r;
  logic                 strobe_nxt;
  logic                 underrun_r;
  logic                 fifo_valid;
  logic                 fifo_ready;
  logic [1:0]           fifo_data;
  logic [1:0]           fifo_in_data;
  logic                 fifo_in_ready;

  // ****************************************************************
  // timing source
  // ****************************************************************
  // the sources arrive as levels synchronous to sys_clk; a rising level
  // marks one output clock period, so each source must stay high and low
  // for one sys_clk cycle at least
  wire src_sel   = loop_timing_sel ? line_receive_clock : transmit_input_clock;
  wire src_rise  = src_r & ~src_d_r;
  wire bit_end   = (state_r == dros_pkg::DROS_ST_BIT) & (phase_r == dros_pkg::BIT_LAST_PHASE);
  wire slot_free = (state_r == dros_pkg::DROS_ST_WAIT) | bit_end;
  wire load      = src_rise & slot_free & fifo_valid;

  // source edge detection and the output clock itself
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_r     <= 1'b0;
      src_d_r   <= 1'b0;
      out_clk_r <= 1'b0;
    end else begin
      src_r     <= src_sel;
      src_d_r   <= src_r;
      out_clk_r <= src_r;
    end
  end

  // ****************************************************************
  // input buffer
  // ****************************************************************
  // the framer is stalled through oh_ready when eight bits wait
  assign fifo_in_data = {oh_first, oh_bit};
  assign fifo_ready   = load;
  assign oh_ready     = fifo_in_ready;

  dros_fifo #(
    .WIDTH (dros_pkg::OH_FIFO_WIDTH),
    .DEPTH (dros_pkg::OH_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .in_valid  (oh_valid),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_valid),
    .out_data  (fifo_data),
    .out_ready (fifo_ready)
  );

  // ****************************************************************
  // bit slot sequencer
  // ****************************************************************
  // a slot opens on a source rise when a bit is buffered and lasts
  // 85 output clocks; with nothing buffered the line idles low
  always_comb begin
    state_nxt  = state_r;
    phase_nxt  = phase_r;
    data_nxt   = data_r;
    marker_nxt = marker_r;
    strobe_nxt = strobe_r;
    if (src_rise) begin
      if (load) begin
        state_nxt  = dros_pkg::DROS_ST_BIT;
        phase_nxt  = dros_pkg::PHASE_ZERO;
        data_nxt   = fifo_data[0];
        marker_nxt = fifo_data[1];
      end else if (bit_end) begin
        state_nxt  = dros_pkg::DROS_ST_WAIT;
        phase_nxt  = dros_pkg::PHASE_ZERO;
        data_nxt   = 1'b0;
        marker_nxt = 1'b0;
      end else if (state_r == dros_pkg::DROS_ST_BIT) begin
        phase_nxt  = phase_r + 7'h01;
      end
      // strobe changes only on output clock rises, so it spans one period
      strobe_nxt = (state_nxt == dros_pkg::DROS_ST_BIT) &
                   (phase_nxt == dros_pkg::STROBE_PHASE);
    end
  end

  // sequencer registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= dros_pkg::DROS_ST_WAIT;
      phase_r    <= dros_pkg::PHASE_ZERO;
      data_r     <= 1'b0;
      marker_r   <= 1'b0;
      strobe_r   <= 1'b0;
      underrun_r <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      phase_r    <= phase_nxt;
      data_r     <= data_nxt;
      marker_r   <= marker_nxt;
      strobe_r   <= strobe_nxt;
      underrun_r <= src_rise & bit_end & ~fifo_valid; // slot ended with nothing to send
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // all link signals change together in the cycle after a source rise
  assign link.receive_output_clock   = out_clk_r;
  assign link.rx_overhead_serial_out = data_r;
  assign link.overhead_sample_strobe = strobe_r;
  assign link.overhead_frame_marker  = marker_r;
  assign underrun_pulse              = underrun_r;
endmodule // dros_rx_oh_dev
`default_nettype wire

/* dros_rx_oh_term.sv */
// terminal end: samples strobed overhead bits and names each by its position
`timescale 1ns/1ps
`default_nettype none
module dros_rx_oh_term (
  // clock and reset
  input  wire logic      sys_clk,
  input  wire logic      arst_n,
  // link from the device
  dros_link_if.term      link,
  // recovered overhead bits
  output logic           sample_valid,
  output logic           sample_bit,
  output logic [5:0]     sample_index,
  output logic [3:0]     sample_kind,
  output logic           frame_locked
);
  logic       clk_d_r;
  logic       seen_r;
  logic [5:0] idx_r;
  logic [5:0] idx_nxt;
  logic       valid_r;
  logic       bit_r;
  logic [3:0] kind_r;
  logic       locked_r;

  // ****************************************************************
  // position decode
  // ****************************************************************
  function automatic dros_pkg::dros_kind_t kind_of(input logic [5:0] idx);
    dros_pkg::dros_kind_t k;
    k = dros_pkg::DROS_KIND_UDL;
    if (idx[0]) begin
      // odd positions repeat F1 F0 F0 F1
      k = (idx[2] == idx[1]) ? dros_pkg::DROS_KIND_F1 : dros_pkg::DROS_KIND_F0;
    end else begin
      case (idx)
        6'h00, 6'h08: k = dros_pkg::DROS_KIND_X;
        6'h02:        k = dros_pkg::DROS_KIND_AIC;
        6'h04:        k = dros_pkg::DROS_KIND_NA;
        6'h06:        k = dros_pkg::DROS_KIND_FEAC;
        6'h10, 6'h18: k = dros_pkg::DROS_KIND_P;
        6'h12, 6'h14, 6'h16: k = dros_pkg::DROS_KIND_CP;
        6'h1A, 6'h1C, 6'h1E: k = dros_pkg::DROS_KIND_FEBE;
        6'h20, 6'h30: k = dros_pkg::DROS_KIND_M0;
        6'h22, 6'h24, 6'h26: k = dros_pkg::DROS_KIND_DL;
        6'h28:        k = dros_pkg::DROS_KIND_M1;
        default:      k = dros_pkg::DROS_KIND_UDL;
      endcase
    end
    return k;
  endfunction

  // ****************************************************************
  // sampling
  // ****************************************************************
  // a falling edge of the output clock with the strobe high is a capture
  wire clk_fall = clk_d_r & ~link.receive_output_clock;
  wire take     = clk_fall & link.overhead_sample_strobe;
  wire marker   = link.overhead_frame_marker;
  wire at_last  = (idx_r == dros_pkg::LAST_OH_IDX);
  // counting saturates at the last position until a marker arrives again
  assign idx_nxt = marker ? dros_pkg::FIRST_OH_IDX :
                   (at_last ? idx_r : idx_r + 6'h01);

  // edge detector and position counter
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_d_r <= 1'b0;
      seen_r  <= 1'b0;
      idx_r   <= dros_pkg::FIRST_OH_IDX;
    end else begin
      clk_d_r <= link.receive_output_clock;
      if (take) begin
        seen_r <= seen_r | marker;
        idx_r  <= idx_nxt;
      end
    end
  end

  // captured bit with its position; nothing is reported before the first marker
  // because positions before it mean nothing
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_r  <= 1'b0;
      bit_r    <= 1'b0;
      kind_r   <= dros_pkg::DROS_KIND_X;
      locked_r <= 1'b0;
    end else begin
      valid_r <= take & (marker | seen_r);
      if (take) begin
        bit_r  <= link.rx_overhead_serial_out;
        kind_r <= kind_of(idx_nxt);
        if (marker) begin
          locked_r <= seen_r & at_last; // a marker right after position 55
        end else if (at_last) begin
          locked_r <= 1'b0;             // a strobe past 55 without a marker
        end
      end
    end
  end

  // outputs straight from registers
  assign sample_valid = valid_r;
  assign sample_bit   = bit_r;
  assign sample_index = idx_r;
  assign sample_kind  = kind_r;
  assign frame_locked = locked_r;
endmodule // dros_rx_oh_term
`default_nettype wire

/* tb_top.sv */
// self-checking bench for both ends of the overhead strobe link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk, arst_n, loop_timing_sel, line_receive_clock, transmit_input_clock;
  logic        oh_valid, oh_bit, oh_first, oh_ready, underrun_pulse;
  logic        sample_valid, sample_bit, frame_locked, ck_d, meas_en, fill_seen, under_seen;
  logic [5:0]  sample_index;
  logic [3:0]  sample_kind;
  logic [6:0]  exp_w;
  logic [6:0]  exp_q[$];
  logic [1:0]  lc_r;
  logic [2:0]  tc_r;
  logic [7:0]  per_r, stb_cnt;
  logic [31:0] seed;
  int          err_total, total_checks, cyc;

  dros_link_if link ();
  dros_rx_oh_dev u_dros_rx_oh_dev (.sys_clk(sys_clk), .arst_n(arst_n), .loop_timing_sel(loop_timing_sel),
    .line_receive_clock(line_receive_clock), .transmit_input_clock(transmit_input_clock),
    .oh_valid(oh_valid), .oh_bit(oh_bit), .oh_first(oh_first), .oh_ready(oh_ready),
    .underrun_pulse(underrun_pulse), .link(link));
  dros_rx_oh_term u_dros_rx_oh_term (.sys_clk(sys_clk), .arst_n(arst_n), .link(link),
    .sample_valid(sample_valid), .sample_bit(sample_bit), .sample_index(sample_index),
    .sample_kind(sample_kind), .frame_locked(frame_locked));
  dros_link_checker u_dros_link_checker (.sys_clk(sys_clk), .arst_n(arst_n),
    .receive_output_clock(link.receive_output_clock), .rx_overhead_serial_out(link.rx_overhead_serial_out),
    .overhead_sample_strobe(link.overhead_sample_strobe), .overhead_frame_marker(link.overhead_frame_marker));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // meaning of the bit at a frame position
  function automatic logic [3:0] kind_of(input logic [5:0] i);
    if (i[0]) return (i[2:0] == 3'h1 || i[2:0] == 3'h7) ? dros_pkg::DROS_KIND_F1 : dros_pkg::DROS_KIND_F0;
    case (i)
      6'h00, 6'h08: return dros_pkg::DROS_KIND_X;
      6'h02: return dros_pkg::DROS_KIND_AIC;
      6'h04: return dros_pkg::DROS_KIND_NA;
      6'h06: return dros_pkg::DROS_KIND_FEAC;
      6'h10, 6'h18: return dros_pkg::DROS_KIND_P;
      6'h12, 6'h14, 6'h16: return dros_pkg::DROS_KIND_CP;
      6'h1A, 6'h1C, 6'h1E: return dros_pkg::DROS_KIND_FEBE;
      6'h20, 6'h30: return dros_pkg::DROS_KIND_M0;
      6'h22, 6'h24, 6'h26: return dros_pkg::DROS_KIND_DL;
      6'h28: return dros_pkg::DROS_KIND_M1;
      default: return dros_pkg::DROS_KIND_UDL;
    endcase
  endfunction

  task automatic check_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic check_num(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t value got %0d exp %0d", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one frame of 56 words, random bits with the last one forced high
  task automatic send_frame;
    logic b;
    for (int i = 0; i < dros_pkg::OH_PER_FRAME; i++) begin
      seed = xs(seed);
      b = (i[5:0] == dros_pkg::LAST_OH_IDX) ? 1'b1 : seed[0];
      oh_valid <= 1'b1;
      oh_bit <= b;
      oh_first <= (i == 0);
      do @(posedge sys_clk); while (oh_ready !== 1'b1);
      exp_q.push_back({i[5:0], b});
    end
    oh_valid <= 1'b0;
  endtask

  // ****************************************************************
  // clocks, sources and monitors
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // line source period 4 cycles, transmit source period 6, so they differ
  always @(posedge sys_clk) begin
    lc_r <= lc_r + 2'h1;
    tc_r <= (tc_r == 3'h5) ? 3'h0 : tc_r + 3'h1;
    line_receive_clock <= lc_r[1];
    transmit_input_clock <= (tc_r >= 3'h3);
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      complete_run();
    end
  end

  // output clock period follows the selected source; strobes counted, refusals and underruns flagged
  always @(posedge sys_clk) begin
    ck_d <= link.receive_output_clock;
    if (link.receive_output_clock && !ck_d) begin
      if (meas_en) check_num(per_r, loop_timing_sel ? 8'h04 : 8'h06);
      per_r <= 8'h01;
    end else per_r <= per_r + 8'h01;
    if (link.receive_output_clock && !ck_d && link.overhead_sample_strobe) stb_cnt <= stb_cnt + 8'h01;
    if (oh_valid && !oh_ready) fill_seen <= 1'b1;
    if (underrun_pulse) under_seen <= 1'b1;
    if (sample_valid === 1'b1) begin
      exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 7'h7F;
      check_bit(sample_bit, exp_w[0]);
      check_num({2'h0, sample_index}, {2'h0, exp_w[6:1]});
      check_num({4'h0, sample_kind}, {4'h0, kind_of(exp_w[6:1])});
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {arst_n, oh_valid, oh_bit, oh_first, line_receive_clock, transmit_input_clock} = 6'h00;
    {ck_d, meas_en, fill_seen, under_seen, lc_r, tc_r, per_r, stb_cnt} = 25'h0000000;
    loop_timing_sel = 1'b1;
    seed = 32'h37A12BD1;
    err_total = 0;
    total_checks = 0;
    cyc = 0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge sys_clk);
    meas_en <= 1'b1;
    send_frame();
    while (exp_q.size() != 0) @(posedge sys_clk);
    repeat (400) @(posedge sys_clk);
    check_num(stb_cnt, 8'h38);
    check_bit(fill_seen, 1'b1);
    check_bit(under_seen, 1'b1);
    meas_en <= 1'b0;
    loop_timing_sel <= 1'b0;
    repeat (20) @(posedge sys_clk);
    meas_en <= 1'b1;
    send_frame();
    while (exp_q.size() != 0) @(posedge sys_clk);
    repeat (400) @(posedge sys_clk);
    check_num(stb_cnt, 8'h70);
    check_bit(frame_locked, 1'b1);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
